// [spw_pkg.sv]
/*
 * spw_pkg: shared constants of the signed audio pwm output.
 * Assumes a 200 MHz system clock and a 32-bit APB register bus.
 */
package spw_pkg;

    // -------------------------------------------------------------------
    // clock and frame timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned FRAME_RATE_HZ = 32_000;
    // rounded down: the frame must not run slower than the fixed rate
    localparam int unsigned FRAME_CYCLES  = CLK_HZ / FRAME_RATE_HZ;
    localparam int unsigned CNT_W         = 13;

    // -------------------------------------------------------------------
    // register indexes; byte address is four times the index
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS    = 8'h00;
    localparam logic [7:0] IDX_EXTRA_LOW = 8'h08;
    localparam logic [7:0] IDX_CTRL      = 8'h09;
    localparam logic [7:0] IDX_LOW       = 8'h0a;
    localparam logic [7:0] IDX_HIGH      = 8'h0b;
    localparam logic [7:0] IDX_CONFIG    = 8'h0c;
    localparam int unsigned ADDR_W       = 10;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int unsigned STATUS_FLAG_BIT = 2;
    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_IRQEN_BIT  = 1;
    localparam int unsigned CFG_TEN_BIT     = 0;
    localparam int unsigned CFG_TWELVE_BIT  = 1;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [3:0] NIBBLE_RST = 4'h0;
    localparam logic [1:0] CTRL_RST   = 2'h0;
    localparam logic [1:0] CFG_RST    = 2'h0;
    localparam logic       FLAG_RST   = 1'b0;

    // -------------------------------------------------------------------
    // sample magnitude width (largest mode, 12 bits signed)
    // -------------------------------------------------------------------
    localparam int unsigned MAG_W = 11;

    typedef enum logic [2:0] {
        RES_8  = 3'b001,
        RES_10 = 3'b010,
        RES_12 = 3'b100
    } spw_res_e;

endpackage

// [spw_frame_timer.sv]
/*
 * spw_frame_timer: free count of clocks within one pwm frame.
 * Assumes run stays low while the generator is off, so a new
 * enable always starts a fresh frame at count zero.
 */
`timescale 1ns/1ps
module spw_frame_timer #(
    parameter int unsigned FRAME_CYCLES = spw_pkg::FRAME_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       run,
    output logic [spw_pkg::CNT_W-1:0]       count,
    output logic                            frame_end
);

    localparam logic [spw_pkg::CNT_W-1:0] LAST = spw_pkg::CNT_W'(FRAME_CYCLES - 1);

    logic [spw_pkg::CNT_W-1:0] count_q;

    always_ff @(posedge clk) begin
        if (rst || !run || count_q == LAST) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

    assign count     = count_q;
    assign frame_end = run && (count_q == LAST);

endmodule // spw_frame_timer

// [spw_pulse_out.sv]
/*
 * spw_pulse_out: drives the differential pin pair from the active sample.
 * Assumes count restarts at zero at each frame start; pins are
 * registered so they lag the count by one clock.
 */
`timescale 1ns/1ps
module spw_pulse_out (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       enable,
    input  wire logic                       halt,
    input  wire logic                       sign,
    input  wire logic [spw_pkg::MAG_W-1:0]  mag,
    input  wire logic [spw_pkg::CNT_W-1:0]  count,
    output logic                            pos_out,
    output logic                            pos_oe,
    output logic                            neg_out,
    output logic                            neg_oe
);

    logic pulse;

    assign pulse = enable && ({2'b00, mag} > count);

    always_ff @(posedge clk) begin
        if (rst) begin
            pos_out <= 1'b0;
            neg_out <= 1'b0;
            pos_oe  <= 1'b1;
            neg_oe  <= 1'b1;
        end else begin
            pos_out <= pulse && !sign && !halt;
            neg_out <= pulse && sign && !halt;
            pos_oe  <= !halt;
            neg_oe  <= !halt;
        end
    end

endmodule // spw_pulse_out

// [spw_audio_pwm.sv]
/*
 * spw_audio_pwm: signed audio pwm generator
 * with an APB register file.
 * Assumes an APB master on the same clock
 * and a HALT_MODE level from the core on the same clock;
 * neither passes a synchroniser.
 * Pins lag the frame count by one clock.
 */
// Operation
// - interrupt request after each emitted frame
// - top sample bit is the sign
// - frame rate fixed at 32 kHz
// - 8-bit: nibbles form sign plus 7-bit length
// - frame end sets the frame done flag
// - frame end loads buffer into active sample
// - unchanged data replays previous sample
// - enable bit; disabled pins driven low
// - halt clears the enable bit
// - halt floats both output pins
// - 10-bit sample uses extra bits 3:2
// - 10-bit magnitude spans 0 to 511
// - 12-bit sample uses all extra bits
// - 12-bit magnitude spans 0 to 2047
// - option chooses 10 or 8 bits
// - twelve-bit option takes precedence
// - global enable gates the request
`timescale 1ns/1ps
module spw_audio_pwm #(
    parameter int unsigned FRAME_CYCLES = spw_pkg::FRAME_CYCLES
) (
    input  wire logic                       CLK,
    input  wire logic                       RST,
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [spw_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [31:0]                PWDATA,
    output logic [31:0]                     PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    input  wire logic                       HALT_MODE,
    output logic                            FRAME_IRQ,
    output logic                            POSITIVE_OUT_PIN,
    output logic                            POSITIVE_OUT_PIN_OE,
    output logic                            NEGATIVE_OUT_PIN,
    output logic                            NEGATIVE_OUT_PIN_OE
);

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    logic [3:0]                sample_low_nibble_q;
    logic [3:0]                sample_high_nibble_q;
    logic [3:0]                sample_extra_low_nibble_q;
    logic                      generator_enable_q;
    logic                      global_irq_enable_q;
    logic                      ten_or_eight_bit_select_q;
    logic                      twelve_bit_select_q;
    logic                      frame_done_flag_q;
    logic                      irq_q;
    logic                      enable_d1_q;
    logic                      active_sign_q;
    logic [spw_pkg::MAG_W-1:0] active_mag_q;
    logic                      pready_q;
    logic                      pslverr_q;
    logic [31:0]               prdata_q;

    logic                      access;
    logic                      commit;
    logic                      wr_commit;
    logic [7:0]                idx;
    logic                      idx_hit;
    logic                      addr_ok;
    logic [31:0]               rd_mux;
    logic                      wr_status;
    logic                      wr_extra;
    logic                      wr_ctrl;
    logic                      wr_low;
    logic                      wr_high;
    logic                      wr_cfg;
    logic                      enable_rise;
    logic                      timer_run;
    logic                      frame_end;
    logic                      load_active;
    logic [spw_pkg::CNT_W-1:0] frame_count;
    spw_pkg::spw_res_e         res_sel;
    logic                      buf_sign;
    logic [spw_pkg::MAG_W-1:0] buf_mag;

    // -------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------
    // one wait state: pready is registered, so each access lasts two cycles
    assign access    = PSEL && PENABLE && !pready_q;
    assign commit    = PSEL && PENABLE && pready_q;
    assign wr_commit = commit && PWRITE && addr_ok;

    assign idx     = PADDR[9:2];
    // only word-aligned addresses decode
    assign idx_hit = (PADDR[1:0] == 2'b00);
    assign addr_ok = idx_hit &&
                     (idx == spw_pkg::IDX_STATUS || idx == spw_pkg::IDX_EXTRA_LOW ||
                      idx == spw_pkg::IDX_CTRL || idx == spw_pkg::IDX_LOW ||
                      idx == spw_pkg::IDX_HIGH || idx == spw_pkg::IDX_CONFIG);

    assign wr_status = wr_commit && (idx == spw_pkg::IDX_STATUS);
    assign wr_extra  = wr_commit && (idx == spw_pkg::IDX_EXTRA_LOW);
    assign wr_ctrl   = wr_commit && (idx == spw_pkg::IDX_CTRL);
    assign wr_low    = wr_commit && (idx == spw_pkg::IDX_LOW);
    assign wr_high   = wr_commit && (idx == spw_pkg::IDX_HIGH);
    assign wr_cfg    = wr_commit && (idx == spw_pkg::IDX_CONFIG);

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (idx_hit) begin
            // sample nibbles are write-only and read as zero
            if (idx == spw_pkg::IDX_STATUS) begin
                rd_mux[spw_pkg::STATUS_FLAG_BIT] = frame_done_flag_q;
            end
            if (idx == spw_pkg::IDX_CTRL) begin
                rd_mux[spw_pkg::CTRL_EN_BIT]    = generator_enable_q;
                rd_mux[spw_pkg::CTRL_IRQEN_BIT] = global_irq_enable_q;
            end
            if (idx == spw_pkg::IDX_CONFIG) begin
                rd_mux[spw_pkg::CFG_TEN_BIT]    = ten_or_eight_bit_select_q;
                rd_mux[spw_pkg::CFG_TWELVE_BIT] = twelve_bit_select_q;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access;
            pslverr_q <= access && !addr_ok;
            if (access && !PWRITE) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // -------------------------------------------------------------------
    // sample buffer nibbles
    // -------------------------------------------------------------------
    // software fills early
    always_ff @(posedge CLK) begin
        if (RST) begin
            sample_low_nibble_q       <= spw_pkg::NIBBLE_RST;
            sample_high_nibble_q      <= spw_pkg::NIBBLE_RST;
            sample_extra_low_nibble_q <= spw_pkg::NIBBLE_RST;
        end else begin
            if (wr_low) begin
                sample_low_nibble_q <= PWDATA[3:0];
            end
            if (wr_high) begin
                sample_high_nibble_q <= PWDATA[3:0];
            end
            if (wr_extra) begin
                sample_extra_low_nibble_q <= PWDATA[3:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // control and resolution options
    // -------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            generator_enable_q  <= spw_pkg::CTRL_RST[spw_pkg::CTRL_EN_BIT];
            global_irq_enable_q <= spw_pkg::CTRL_RST[spw_pkg::CTRL_IRQEN_BIT];
        end else begin
            if (wr_ctrl) begin
                global_irq_enable_q <= PWDATA[spw_pkg::CTRL_IRQEN_BIT];
            end
            if (HALT_MODE) begin
                generator_enable_q <= 1'b0;
            end else if (wr_ctrl) begin
                generator_enable_q <= PWDATA[spw_pkg::CTRL_EN_BIT];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ten_or_eight_bit_select_q <= spw_pkg::CFG_RST[spw_pkg::CFG_TEN_BIT];
            twelve_bit_select_q       <= spw_pkg::CFG_RST[spw_pkg::CFG_TWELVE_BIT];
        end else if (wr_cfg) begin
            ten_or_eight_bit_select_q <= PWDATA[spw_pkg::CFG_TEN_BIT];
            twelve_bit_select_q       <= PWDATA[spw_pkg::CFG_TWELVE_BIT];
        end
    end

    // -------------------------------------------------------------------
    // sample assembly
    // -------------------------------------------------------------------
    // twelve wins
    always_comb begin
        if (twelve_bit_select_q) begin
            res_sel = spw_pkg::RES_12;
        end else if (ten_or_eight_bit_select_q) begin
            res_sel = spw_pkg::RES_10;
        end else begin
            res_sel = spw_pkg::RES_8;
        end
    end

    assign buf_sign = sample_high_nibble_q[3];

    always_comb begin
        buf_mag = '0;
        unique case (res_sel)
            spw_pkg::RES_12: begin
                buf_mag = {sample_high_nibble_q[2:0], sample_low_nibble_q,
                           sample_extra_low_nibble_q};
            end
            spw_pkg::RES_10: begin
                buf_mag = {2'b00, sample_high_nibble_q[2:0], sample_low_nibble_q,
                           sample_extra_low_nibble_q[3:2]};
            end
            spw_pkg::RES_8: begin
                buf_mag = {4'h0, sample_high_nibble_q[2:0], sample_low_nibble_q};
            end
            default: begin
                buf_mag = '0;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // frame timing
    // -------------------------------------------------------------------
    spw_frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_timer (
        .clk       (CLK),
        .rst       (RST),
        .run       (timer_run),
        .count     (frame_count),
        .frame_end (frame_end)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            enable_d1_q <= 1'b0;
        end else begin
            enable_d1_q <= generator_enable_q;
        end
    end

    // a fresh enable loads at once so the first frame is not stale
    assign enable_rise = generator_enable_q && !enable_d1_q;
    assign load_active = enable_rise || frame_end;

    // timer waits out the load cycle: first pulse full length
    assign timer_run   = generator_enable_q && !enable_rise;

    // -------------------------------------------------------------------
    // active sample (double buffer)
    // -------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            active_sign_q <= 1'b0;
            active_mag_q  <= '0;
        end else if (load_active) begin
            active_sign_q <= buf_sign;
            active_mag_q  <= buf_mag;
        end
    end

    // -------------------------------------------------------------------
    // frame done flag and request
    // -------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            frame_done_flag_q <= spw_pkg::FLAG_RST;
        end else if (frame_end) begin
            frame_done_flag_q <= 1'b1;
        end else if (wr_status && !PWDATA[spw_pkg::STATUS_FLAG_BIT]) begin
            frame_done_flag_q <= 1'b0;
        end
    end

    // irq follows the flag; a same-cycle clear loses
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (frame_done_flag_q || frame_end) && global_irq_enable_q &&
                     !(wr_status && !PWDATA[spw_pkg::STATUS_FLAG_BIT] && !frame_end);
        end
    end

    // -------------------------------------------------------------------
    // pin drivers
    // -------------------------------------------------------------------
    // low while disabled
    spw_pulse_out u_pins (
        .clk     (CLK),
        .rst     (RST),
        .enable  (timer_run),
        .halt    (HALT_MODE),
        .sign    (active_sign_q),
        .mag     (active_mag_q),
        .count   (frame_count),
        .pos_out (POSITIVE_OUT_PIN),
        .pos_oe  (POSITIVE_OUT_PIN_OE),
        .neg_out (NEGATIVE_OUT_PIN),
        .neg_oe  (NEGATIVE_OUT_PIN_OE)
    );

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign PRDATA    = prdata_q;
    assign PREADY    = pready_q;
    assign PSLVERR   = pslverr_q;
    assign FRAME_IRQ = irq_q;

endmodule // spw_audio_pwm

// [spw_audio_pwm_checker.sv]
/*
 * spw_audio_pwm_checker: port-level checks of the audio pwm top.
 * Assumes one clock domain and the sync active-high reset.
 */
`timescale 1ns/1ps
module spw_audio_pwm_checker #(
    parameter int unsigned FRAME_CYCLES = spw_pkg::FRAME_CYCLES
) (
    input wire logic                       CLK,
    input wire logic                       RST,
    input wire logic                       PSEL,
    input wire logic                       PENABLE,
    input wire logic                       PWRITE,
    input wire logic [spw_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0]                PWDATA,
    input wire logic [31:0]                PRDATA,
    input wire logic                       PREADY,
    input wire logic                       PSLVERR,
    input wire logic                       HALT_MODE,
    input wire logic                       FRAME_IRQ,
    input wire logic                       POSITIVE_OUT_PIN,
    input wire logic                       POSITIVE_OUT_PIN_OE,
    input wire logic                       NEGATIVE_OUT_PIN,
    input wire logic                       NEGATIVE_OUT_PIN_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // -------------------------------------------------------------------
    // pulse run length
    // -------------------------------------------------------------------
    logic [15:0] run_q;
    always_ff @(posedge CLK) begin
        if (RST || !(POSITIVE_OUT_PIN || NEGATIVE_OUT_PIN)) begin
            run_q <= 16'h0000;
        end else begin
            run_q <= run_q + 16'h0001;
        end
    end

    pins_exclusive_a: assert property (!(POSITIVE_OUT_PIN && NEGATIVE_OUT_PIN))
        else $error("both pins high");
    pulse_in_frame_a: assert property (run_q < FRAME_CYCLES)
        else $error("pulse longer than a frame");
    halt_float_a: assert property (HALT_MODE |=> !POSITIVE_OUT_PIN_OE && !NEGATIVE_OUT_PIN_OE)
        else $error("pins driven in halt");
    halt_low_a: assert property (HALT_MODE |=> !POSITIVE_OUT_PIN && !NEGATIVE_OUT_PIN)
        else $error("pulse during halt");
    reset_state_a: assert property ($fell(RST) |-> !POSITIVE_OUT_PIN && !NEGATIVE_OUT_PIN
        && POSITIVE_OUT_PIN_OE && NEGATIVE_OUT_PIN_OE && !FRAME_IRQ)
        else $error("bad pin state after reset");
    irq_gate_a: assert property (PSEL && PENABLE && PREADY && PWRITE && !PSLVERR
        && PADDR == 10'h024 && !PWDATA[1] |-> ##2 !FRAME_IRQ)
        else $error("irq with global enable off");
    ready_wait_a: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |=> PREADY)
        else $error("no ready after one wait state");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
endmodule // spw_audio_pwm_checker

bind spw_audio_pwm spw_audio_pwm_checker #(.FRAME_CYCLES(FRAME_CYCLES)) chk (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .HALT_MODE(HALT_MODE),
    .FRAME_IRQ(FRAME_IRQ), .POSITIVE_OUT_PIN(POSITIVE_OUT_PIN), .POSITIVE_OUT_PIN_OE(POSITIVE_OUT_PIN_OE),
    .NEGATIVE_OUT_PIN(NEGATIVE_OUT_PIN), .NEGATIVE_OUT_PIN_OE(NEGATIVE_OUT_PIN_OE));

// [spw_speaker.sv]
/*
 * spw_speaker: differential speaker load that measures each pulse.
 * Assumes the pin pair is sampled on the system clock.
 */
`timescale 1ns/1ps
module spw_speaker (
    input  wire logic clk,
    input  wire logic pos_pin,
    input  wire logic pos_oe,
    input  wire logic neg_pin,
    input  wire logic neg_oe,
    output int        pulses,
    output int        last_len,
    output int        period,
    output logic      last_neg,
    output logic      floating
);
    int   run_q;
    int   since_q;
    // undriven pin reads as z, so a floating pair never counts as a pulse
    wire logic pos_w = pos_oe ? pos_pin : 1'bz;
    wire logic neg_w = neg_oe ? neg_pin : 1'bz;
    assign floating = !pos_oe && !neg_oe;

    initial begin
        pulses = 0;
        last_len = 0;
        period = 0;
        last_neg = 1'b0;
        run_q = 0;
        since_q = 0;
    end

    always @(posedge clk) begin
        since_q <= since_q + 1;
        if (pos_w === 1'b1 || neg_w === 1'b1) begin
            if (run_q == 0) begin
                period <= since_q + 1;
                since_q <= 0;
            end
            run_q <= run_q + 1;
            last_neg <= (neg_w === 1'b1);
        end else if (run_q != 0) begin
            last_len <= run_q;
            pulses <= pulses + 1;
            run_q <= 0;
        end
    end
endmodule // spw_speaker

// [tb_spw_audio_pwm.sv]
/*
 * tb_spw_audio_pwm: register-level test of the audio pwm generator.
 * Assumes a shortened frame of FC clocks and a speaker load model.
 */
`timescale 1ns/1ps
module tb_spw_audio_pwm;
    localparam int FC = 64;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic        HALT_MODE = 1'b0;
    logic [9:0]  PADDR = 10'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA, rdata;
    logic        PREADY, PSLVERR, FRAME_IRQ, POS, POS_OE, NEG, NEG_OE, rerr, last_neg, floating;
    int          errors = 0, check_count = 0, pulses, last_len, period, n;
    logic [3:0]  cfg_t [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0};
    logic [3:0]  high_t [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h8};
    int          mag_t [5] = '{2, 11, 44, 44, 2};

    always #2.5 CLK = ~CLK;

    spw_audio_pwm #(.FRAME_CYCLES(FC)) dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .HALT_MODE(HALT_MODE), .FRAME_IRQ(FRAME_IRQ), .POSITIVE_OUT_PIN(POS),
        .POSITIVE_OUT_PIN_OE(POS_OE), .NEGATIVE_OUT_PIN(NEG), .NEGATIVE_OUT_PIN_OE(NEG_OE));
    spw_speaker spk (.clk(CLK), .pos_pin(POS), .pos_oe(POS_OE), .neg_pin(NEG), .neg_oe(NEG_OE),
        .pulses(pulses), .last_len(last_len), .period(period), .last_neg(last_neg), .floating(floating));

    // -------------------------------------------------------------------
    // reporting
    // -------------------------------------------------------------------
    task automatic mismatch(input string msg);
        errors++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) mismatch($sformatf("%s got %h exp %h", msg, got, exp));
    endtask
    task automatic chk_num(input int got, input int exp, input string msg);
        check_count++;
        if (got != exp) mismatch($sformatf("%s got %0d exp %0d", msg, got, exp));
    endtask

    // -------------------------------------------------------------------
    // apb master; entered just after a rising edge
    // -------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        int k;
        PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= wd; PENABLE <= 1'b0;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin @(posedge CLK); k++; end while (PREADY !== 1'b1 && k < 20);
        if (k >= 20) begin mismatch("apb hang"); complete_run(); end
        rdata = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, {idx, 2'b00}, d);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, {idx, 2'b00}, 32'h0000_0000);
        chk_word(rdata, exp, "register read");
    endtask
    task automatic wait_pulses(input int k);
        int base, c;
        base = pulses;
        c = 0;
        while (pulses < base + k && c < 4 * FC * k) begin @(posedge CLK); c++; end
        if (pulses < base + k) begin mismatch("no pulse"); complete_run(); end
    endtask

    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rd_chk(spw_pkg::IDX_CTRL, 32'h0);
        rd_chk(spw_pkg::IDX_STATUS, 32'h0);
        rd_chk(spw_pkg::IDX_CONFIG, 32'h0);
        chk_word({POS_OE, NEG_OE, POS, NEG}, 32'hc, "pins after reset");
        apb(1'b0, 10'h3fc, 32'h0);
        chk_word({rdata[30:0], rerr}, 32'h1, "unmapped read");
        apb(1'b1, 10'h025, 32'h1);
        chk_word(rerr, 32'h1, "misaligned write");
        rd_chk(spw_pkg::IDX_CTRL, 32'h0);
        // ---------------------------------------------------------------
        // every resolution and both signs
        // ---------------------------------------------------------------
        for (int i = 0; i < 5; i++) begin
            wr(spw_pkg::IDX_CONFIG, {28'h0, cfg_t[i]});
            wr(spw_pkg::IDX_EXTRA_LOW, 32'hc);
            wr(spw_pkg::IDX_LOW, 32'h2);
            wr(spw_pkg::IDX_HIGH, {28'h0, high_t[i]});
            wr(spw_pkg::IDX_CTRL, 32'h1);
            wait_pulses(2);
            chk_num(last_len, mag_t[i], "pulse length");
            chk_num(int'(last_neg), int'(high_t[i][3]), "pulse pin");
            chk_num(period, FC, "frame period");
            wr(spw_pkg::IDX_CTRL, 32'h0);
            repeat (3) @(posedge CLK);
            chk_word({POS_OE, NEG_OE, POS, NEG}, 32'hc, "pins when disabled");
        end
        // ---------------------------------------------------------------
        // flag, interrupt, replay and reload
        // ---------------------------------------------------------------
        wr(spw_pkg::IDX_CONFIG, 32'h0);
        wr(spw_pkg::IDX_HIGH, 32'h0);
        wr(spw_pkg::IDX_LOW, 32'h2);
        wr(spw_pkg::IDX_CTRL, 32'h3);
        wait_pulses(3);
        chk_num(last_len, 2, "replayed sample");
        chk_word(FRAME_IRQ, 32'h1, "frame irq");
        rd_chk(spw_pkg::IDX_STATUS, 32'h4);
        wr(spw_pkg::IDX_LOW, 32'h5);
        wait_pulses(2);
        chk_num(last_len, 5, "reloaded sample");
        wr(spw_pkg::IDX_STATUS, 32'h0);
        rd_chk(spw_pkg::IDX_STATUS, 32'h0);
        wait_pulses(1);
        wr(spw_pkg::IDX_CTRL, 32'h1);
        repeat (2) @(posedge CLK);
        chk_word(FRAME_IRQ, 32'h0, "irq gated");
        rd_chk(spw_pkg::IDX_STATUS, 32'h4);
        // ---------------------------------------------------------------
        // halt, then a reset in mid-run
        // ---------------------------------------------------------------
        HALT_MODE <= 1'b1;
        repeat (3) @(posedge CLK);
        chk_word(floating, 32'h1, "pins float in halt");
        HALT_MODE <= 1'b0;
        @(posedge CLK);
        rd_chk(spw_pkg::IDX_CTRL, 32'h0);
        chk_word({POS_OE, NEG_OE, POS, NEG}, 32'hc, "pins after halt");
        wr(spw_pkg::IDX_CTRL, 32'h3);
        wait_pulses(1);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rd_chk(spw_pkg::IDX_CTRL, 32'h0);
        chk_word({POS_OE, NEG_OE, POS, NEG, FRAME_IRQ}, 32'h18, "pins after reset");
        complete_run();
    end
endmodule // tb_spw_audio_pwm
